/* File: hw/fct_pkg.sv */
// Purpose: Shared constants and types for the fixed-cycle timer block
// Assumes: 125 MHz system clock, byte-wide register port
// Notes:   Auto-release counts derive from times in ns and the clock period

package fct_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic [7:0] fct_byte_t;
	typedef logic [11:0] fct_count_t;

	typedef enum logic [1:0] {
		FCT_IDLE = 2'b01,
		FCT_RUN  = 2'b10
	} fct_state_t;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam fct_byte_t ADDR_PRESET_LOW = 8'h0B;
	localparam fct_byte_t ADDR_PRESET_HIGH = 8'h0C;
	localparam fct_byte_t ADDR_EXT_CONFIG = 8'h0D;
	localparam fct_byte_t ADDR_EVENT_FLAGS = 8'h0E;
	localparam fct_byte_t ADDR_IRQ_CONTROL = 8'h0F;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EXT_RUN_ENABLE_BIT = 4;
	localparam int EXT_SRC_HI_BIT = 1;
	localparam int EXT_SRC_LO_BIT = 0;
	localparam int FLAG_TIMER_EVENT_BIT = 4;
	localparam int CTL_TIMER_IRQ_EN_BIT = 4;
	localparam fct_byte_t FLAG_WRITABLE_MASK = 8'h10;
	localparam fct_byte_t CTL_WRITABLE_MASK = 8'hFD;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam fct_byte_t RST_PRESET_LOW = 8'h00;
	localparam fct_byte_t RST_PRESET_HIGH = 8'h00;
	localparam fct_byte_t RST_EXT_CONFIG = 8'h00;
	localparam fct_byte_t RST_IRQ_CONTROL = 8'h00;
	localparam fct_count_t RST_COUNT = 12'h000;
	localparam fct_count_t COUNT_ONE = 12'h001;

	// ------------------------------------------------------------
	// Source select codes
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_4096HZ = 2'b00;
	localparam logic [1:0] SRC_64HZ = 2'b01;
	localparam logic [1:0] SRC_SECOND = 2'b10;
	localparam logic [1:0] SRC_MINUTE = 2'b11;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int RTN_SHORT_NS = 122000;
	localparam int RTN_LONG_NS = 7812500;
	// Longest times, so rounded down
	localparam int RTN_SHORT_CYCLES = RTN_SHORT_NS / CLK_PERIOD_NS;
	localparam int RTN_LONG_CYCLES = RTN_LONG_NS / CLK_PERIOD_NS;
	localparam int RTN_CNT_W = 20;

endpackage : fct_pkg

/* File: hw/fct_rel_if.sv */
// Purpose: Carries auto-release requests between the timer and its release counter
// Assumes: One clock domain
// Notes:   start and abort are single-cycle pulses

interface fct_rel_if;
	logic start;
	logic abort;
	logic long_sel;
	logic done;

	modport ctrl (output start, output abort, output long_sel, input done);
	modport cnt (input start, input abort, input long_sel, output done);
endinterface : fct_rel_if

/* File: hw/fct_release.sv */
// Purpose: Counts the interrupt auto-release period after each event that sets the interrupt (timer irq enabled)
// Assumes: start and abort are one-cycle pulses, ce freezes the count
// Notes:   done pulses once when the period has elapsed

module fct_release #(
	parameter int SHORT_CYCLES = fct_pkg::RTN_SHORT_CYCLES,
	parameter int LONG_CYCLES = fct_pkg::RTN_LONG_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	fct_rel_if.cnt rel
);
	import fct_pkg::*;

	localparam logic [RTN_CNT_W-1:0] SHORT_LOAD = RTN_CNT_W'(SHORT_CYCLES - 1);
	localparam logic [RTN_CNT_W-1:0] LONG_LOAD = RTN_CNT_W'(LONG_CYCLES - 1);

	logic [RTN_CNT_W-1:0] cnt_q;
	logic busy_q;
	logic done_q;

	wire expire = busy_q && (cnt_q == '0) && !rel.start;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= expire;
			if (rel.start) begin
				cnt_q <= rel.long_sel ? LONG_LOAD : SHORT_LOAD;
				busy_q <= 1'b1;
			end else if (rel.abort || expire) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	assign rel.done = done_q;

endmodule // fct_release

/* File: hw/fct_timer.sv */
// Purpose: Fixed-cycle countdown timer with event flag and shared interrupt output
// Assumes: Serial bus engine presents completed byte writes and reads on a byte port
// Notes:   Source ticks are one-cycle pulses from the clock dividers and update logic

module fct_timer #(
	parameter int SHORT_CYCLES = fct_pkg::RTN_SHORT_CYCLES,
	parameter int LONG_CYCLES = fct_pkg::RTN_LONG_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire fct_pkg::fct_byte_t reg_addr,
	input wire fct_pkg::fct_byte_t reg_wdata,
	output fct_pkg::fct_byte_t reg_rdata,
	input wire logic tick_4096hz,
	input wire logic tick_64hz,
	input wire logic tick_second,
	input wire logic tick_minute,
	input wire logic clock_halt,
	input wire logic update_irq_req,
	input wire logic alarm_irq_req,
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic timer_event,
	output logic timer_running
);
	import fct_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic addr_hit(input fct_byte_t a, input fct_byte_t b);
		addr_hit = (a == b);
	endfunction

	function automatic logic pick_tick(input logic [1:0] sel, input logic [3:0] ticks);
		pick_tick = ticks[sel];
	endfunction

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	fct_byte_t preset_low_q;
	fct_byte_t preset_high_q;
	fct_byte_t ext_config_q;
	fct_byte_t irq_control_q;
	logic timer_event_flag_q;
	fct_byte_t rdata_q;

	// ------------------------------------------------------------
	// Countdown and interrupt state
	// ------------------------------------------------------------
	fct_state_t state_q;
	fct_state_t state_d;
	fct_count_t count_q;
	fct_count_t count_d;
	logic irq_low_q;
	logic event_q;

	fct_rel_if rel ();

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire hit_low = addr_hit(reg_addr, ADDR_PRESET_LOW);
	wire hit_high = addr_hit(reg_addr, ADDR_PRESET_HIGH);
	wire hit_ext = addr_hit(reg_addr, ADDR_EXT_CONFIG);
	wire hit_flags = addr_hit(reg_addr, ADDR_EVENT_FLAGS);
	wire hit_ctl = addr_hit(reg_addr, ADDR_IRQ_CONTROL);

	wire wr_low = reg_wr && hit_low;
	wire wr_high = reg_wr && hit_high;
	wire wr_ext = reg_wr && hit_ext;
	wire wr_flags = reg_wr && hit_flags;
	wire wr_ctl = reg_wr && hit_ctl;

	// ------------------------------------------------------------
	// Field views
	// ------------------------------------------------------------
	wire timer_run_enable = ext_config_q[EXT_RUN_ENABLE_BIT];
	wire source_select_hi = ext_config_q[EXT_SRC_HI_BIT];
	wire source_select_lo = ext_config_q[EXT_SRC_LO_BIT];
	wire [1:0] source_sel = {source_select_hi, source_select_lo};
	wire timer_irq_enable = irq_control_q[CTL_TIMER_IRQ_EN_BIT];
	wire fct_count_t preset = {preset_high_q[3:0], preset_low_q};

	wire new_run_enable = reg_wdata[EXT_RUN_ENABLE_BIT];
	wire new_irq_enable = reg_wdata[CTL_TIMER_IRQ_EN_BIT];
	wire new_event_flag = reg_wdata[FLAG_TIMER_EVENT_BIT];

	// Run enable going 0 to 1 on the completing write starts the count
	wire run_start = wr_ext && new_run_enable && !timer_run_enable;
	wire run_stop = wr_ext && !new_run_enable && timer_run_enable;

	// ------------------------------------------------------------
	// Source clock selection
	// ------------------------------------------------------------
	// Second and minute ticks come straight from the calendar update strobes,
	// so steps and events land on the update instants
	wire [3:0] ticks = {tick_minute, tick_second, tick_64hz, tick_4096hz};
	wire src_halted = clock_halt && (source_sel != SRC_4096HZ);
	wire step = pick_tick(source_sel, ticks) && !src_halted;

	// ------------------------------------------------------------
	// Countdown state machine
	// ------------------------------------------------------------
	logic fire;

	always_comb begin
		state_d = state_q;
		count_d = count_q;
		fire = 1'b0;
		case (state_q)
			FCT_IDLE: begin
				if (run_start) begin
					state_d = FCT_RUN;
					count_d = preset;
				end
			end
			FCT_RUN: begin
				if (run_stop) begin
					state_d = FCT_IDLE;
				end else if (step) begin
					if (count_q == COUNT_ONE) begin
						fire = 1'b1;
						count_d = preset;
					end else if (count_q == RST_COUNT) begin
						// Zero preset never fires; keep reloading
						count_d = preset;
					end else begin
						count_d = count_q - COUNT_ONE;
					end
				end
			end
			default: begin
				state_d = FCT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= FCT_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= RST_COUNT;
		end else if (ce) begin
			count_q <= count_d;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Preset writes while running are stored as is; the host keeps them apart
	wire fct_byte_t preset_low_d = wr_low ? reg_wdata : preset_low_q;
	wire fct_byte_t preset_high_d = wr_high ? reg_wdata : preset_high_q;
	wire fct_byte_t ext_config_d = wr_ext ? reg_wdata : ext_config_q;
	wire fct_byte_t irq_control_d = wr_ctl ? (reg_wdata & CTL_WRITABLE_MASK) : irq_control_q;

	// ------------------------------------------------------------
	// Register flip-flops
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			preset_low_q <= RST_PRESET_LOW;
		end else if (ce) begin
			preset_low_q <= preset_low_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			preset_high_q <= RST_PRESET_HIGH;
		end else if (ce) begin
			preset_high_q <= preset_high_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_config_q <= RST_EXT_CONFIG;
		end else if (ce) begin
			ext_config_q <= ext_config_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_control_q <= RST_IRQ_CONTROL;
		end else if (ce) begin
			irq_control_q <= irq_control_d;
		end
	end

	// ------------------------------------------------------------
	// Event flag
	// ------------------------------------------------------------
	// A new event beats a clear written in the same cycle
	wire flag_clear = wr_flags && !new_event_flag;

	always_ff @(posedge clk) begin
		if (srst) begin
			timer_event_flag_q <= 1'b0;
		end else if (ce) begin
			if (fire) begin
				timer_event_flag_q <= 1'b1;
			end else if (flag_clear) begin
				timer_event_flag_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	wire irq_set = fire && timer_irq_enable;
	wire irq_flag_drop = flag_clear && timer_event_flag_q;
	wire irq_en_drop = wr_ctl && !new_irq_enable && timer_irq_enable;
	wire irq_release = rel.done || irq_flag_drop || irq_en_drop || run_stop;

	assign rel.start = ce && irq_set;
	assign rel.abort = ce && irq_release && !irq_set;
	assign rel.long_sel = (source_sel != SRC_4096HZ);

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_low_q <= 1'b0;
		end else if (ce) begin
			if (irq_set) begin
				irq_low_q <= 1'b1;
			end else if (irq_release) begin
				irq_low_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Auto-release counter
	// ------------------------------------------------------------
	// Run stop releases at once, well inside the auto-release bound
	fct_release #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) u_release (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.rel(rel)
	);

	// ------------------------------------------------------------
	// Shared open-drain pin
	// ------------------------------------------------------------
	// Open-drain: only ever pull low
	wire irq_any = irq_low_q || update_irq_req || alarm_irq_req;
	assign irq_n_out = 1'b0;
	assign irq_n_oe = irq_any;

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			event_q <= 1'b0;
		end else if (ce) begin
			event_q <= fire;
		end
	end

	assign timer_event = event_q;
	assign timer_running = (state_q == FCT_RUN);

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Only the timer flag lives here; other flag bits belong to other blocks
	wire fct_byte_t flags_view = FLAG_WRITABLE_MASK & {8{timer_event_flag_q}};
	fct_byte_t rd_mux;

	always_comb begin
		if (hit_low) begin
			rd_mux = preset_low_q;
		end else if (hit_high) begin
			rd_mux = preset_high_q;
		end else if (hit_ext) begin
			rd_mux = ext_config_q;
		end else if (hit_flags) begin
			rd_mux = flags_view;
		end else if (hit_ctl) begin
			rd_mux = irq_control_q;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Read data register
	// ------------------------------------------------------------
	wire fct_byte_t rdata_d = reg_rd ? rd_mux : rdata_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule // fct_timer

/* File: sim/fct_src_model.sv */
// Purpose: Source tick generator and pulled-up interrupt wire
// Assumes: Tick periods shortened to a few cycles each
// Notes:   Released line reads high through the pull-up

module fct_src_model (
	input wire logic clk,
	input wire logic srst,
	output logic [3:0] tick,
	input wire logic irq_n_oe,
	input wire logic irq_n_out,
	output logic irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P[4] = '{6, 9, 13, 15};
	int c[4] = '{0, 0, 0, 0};
	initial tick = 4'h0;
	assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;
	// One-cycle pulses; each source repeats on its own fixed period of cycles
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			c[i] <= (srst || c[i] == P[i] - 1) ? 0 : c[i] + 1;
			tick[i] <= !srst && c[i] == P[i] - 1;
		end
	end
endmodule : fct_src_model

/* File: sim/fct_timer_assertions.sv */
// Purpose: Port-level checks for the fixed-cycle timer
// Assumes: One clock, synchronous active-high reset, writes and reads count only with ce high
// Notes:   Release bound allows one cycle of slack

module fct_timer_assertions #(
	parameter int SHORT_CYCLES = 10,
	parameter int LONG_CYCLES = 40
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire fct_pkg::fct_byte_t reg_addr,
	input wire fct_pkg::fct_byte_t reg_wdata,
	input wire fct_pkg::fct_byte_t reg_rdata,
	input wire logic update_irq_req,
	input wire logic alarm_irq_req,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic timer_event,
	input wire logic timer_running
);
	import fct_pkg::*;
	// --------
	// Helpers
	// --------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic tie_q;
	logic src0_q;
	int oe_cnt_q;
	int rel_lim;
	wire logic ext_rq = update_irq_req || alarm_irq_req;
	wire logic wr_ok = ce && reg_wr;
	wire logic rd_ok = ce && reg_rd;
	wire logic wr_ext = wr_ok && reg_addr == ADDR_EXT_CONFIG;
	// Length follows the source seen at the last select write
	assign rel_lim = src0_q ? SHORT_CYCLES + 2 : LONG_CYCLES + 2;
	always_ff @(posedge clk) begin
		if (srst) begin
			tie_q <= 1'b0;
			src0_q <= 1'b1;
			oe_cnt_q <= 0;
		end else begin
			if (wr_ok && reg_addr == ADDR_IRQ_CONTROL)
				tie_q <= reg_wdata[CTL_TIMER_IRQ_EN_BIT];
			if (wr_ext)
				src0_q <= reg_wdata[1:0] == SRC_4096HZ;
			oe_cnt_q <= (irq_n_oe && !ext_rq) ? oe_cnt_q + 1 : 0;
		end
	end
	sequence s_clr(a, b);
		wr_ok && reg_addr == a && !reg_wdata[b];
	endsequence
	property p_release(a, b);
		s_clr(a, b) |=> !irq_n_oe || timer_event || ext_rq;
	endproperty
	// --------
	// Checks
	// --------
	a_rd_unmapped: assert property (rd_ok && (reg_addr < ADDR_PRESET_LOW || reg_addr > ADDR_IRQ_CONTROL) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_flag_fixed: assert property (rd_ok && reg_addr == ADDR_EVENT_FLAGS |=> (reg_rdata & ~FLAG_WRITABLE_MASK) == 8'h00)
		else $error("flag fixed bits set");
	a_event_drives: assert property (timer_event && tie_q |-> irq_n_oe)
		else $error("event did not pull irq");
	a_rise_cause: assert property ($rose(irq_n_oe) && !ext_rq |-> timer_event && tie_q)
		else $error("irq without enabled event");
	a_idle_quiet: assert property (!$past(timer_running) |-> !timer_event)
		else $error("event while stopped");
	a_run_start: assert property (wr_ext && reg_wdata[EXT_RUN_ENABLE_BIT] |=> timer_running)
		else $error("run enable did not start");
	a_run_stop: assert property (s_clr(ADDR_EXT_CONFIG, EXT_RUN_ENABLE_BIT) |=> !timer_running)
		else $error("run clear did not stop");
	a_flag_release: assert property (p_release(ADDR_EVENT_FLAGS, FLAG_TIMER_EVENT_BIT))
		else $error("flag clear kept irq");
	a_tie_release: assert property (p_release(ADDR_IRQ_CONTROL, CTL_TIMER_IRQ_EN_BIT))
		else $error("enable clear kept irq");
	a_run_release: assert property (p_release(ADDR_EXT_CONFIG, EXT_RUN_ENABLE_BIT))
		else $error("run clear kept irq");
	a_shared_or: assert property (ext_rq |-> irq_n_oe && !irq_n_out)
		else $error("shared request not driven");
	a_release_bound: assert property (oe_cnt_q <= rel_lim)
		else $error("irq held too long");
endmodule : fct_timer_assertions

bind fct_timer fct_timer_assertions #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_chk (.*);

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the fixed-cycle timer
// Assumes: Release counts shortened to 10 and 40 cycles
// Notes:   Read data is scored from a queue of expected bytes

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fct_pkg::*;
	localparam int SC = 10;
	localparam int LC = 40;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	fct_byte_t reg_addr = 8'h00;
	fct_byte_t reg_wdata = 8'h00;
	fct_byte_t reg_rdata;
	fct_byte_t d;
	fct_byte_t exp_q[$];
	logic [3:0] tick;
	logic [1:0] src = 2'b00;
	logic halt = 1'b0;
	logic upd = 1'b0;
	logic alm = 1'b0;
	logic rd_d = 1'b0;
	logic irq_n_out, irq_n_oe, timer_event, timer_running, irq_pin;
	int fail_count = 0;
	int num_checks = 0;
	int seed = 32'h9203CE5C;
	int tcnt = 0, gap = 0, ocnt = 0, olen = 0, nev = 0;

	always #4 clk = ~clk;

	fct_timer #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) uut (.clk(clk), .srst(srst), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tick_4096hz(tick[0]), .tick_64hz(tick[1]), .tick_second(tick[2]), .tick_minute(tick[3]),
		.clock_halt(halt), .update_irq_req(upd), .alarm_irq_req(alm), .irq_n_out(irq_n_out),
		.irq_n_oe(irq_n_oe), .timer_event(timer_event), .timer_running(timer_running));
	fct_src_model src_m (.clk(clk), .srst(srst), .tick(tick), .irq_n_oe(irq_n_oe),
		.irq_n_out(irq_n_out), .irq_pin(irq_pin));

	// --------
	// Monitors
	// --------
	always @(posedge clk) begin
		rd_d <= reg_rd;
		ocnt <= irq_n_oe ? ocnt + 1 : 0;
		if (!irq_n_oe && ocnt > 0)
			olen <= ocnt;
		if (timer_event) begin
			gap <= tcnt;
			tcnt <= tick[src];
		end else
			tcnt <= tcnt + tick[src];
	end
	always @(negedge clk)
		if (rd_d)
			check(reg_rdata, exp_q.pop_front());

	// --------
	// Tasks
	// --------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input fct_byte_t a, input fct_byte_t v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input fct_byte_t a, input fct_byte_t e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic wait_for(input bit ev, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (ev ? timer_event === 1'b1 : irq_n_oe === 1'b0)
				return;
		end
		fail_count++;
		$display("[FAIL] %0t wait expired", $time);
		complete_run();
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// --------
	// Sequence
	// --------
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		for (int a = 10; a <= 16; a++)
			rd(8'(a), 8'h00);
		d = 8'($random(seed));
		wr(ADDR_PRESET_LOW, d);
		rd(ADDR_PRESET_LOW, d);
		d = 8'($random(seed));
		wr(ADDR_PRESET_HIGH, d);
		rd(ADDR_PRESET_HIGH, d);
		wr(ADDR_EVENT_FLAGS, 8'hFF);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'hFF);
		rd(ADDR_IRQ_CONTROL, 8'hFD);
		wr(ADDR_PRESET_LOW, 8'h08);
		wr(ADDR_PRESET_HIGH, {d[7:4], 4'h0});
		for (int s = 0; s < 4; s++) begin
			src <= 2'(s);
			wr(ADDR_EXT_CONFIG, 8'h10 | 8'(s));
			@(negedge clk);
			check(timer_running, 1'b1);
			wait_for(1, 300);
			check(irq_n_oe, 1'b1);
			wait_for(1, 300);
			@(negedge clk);
			check(gap, 8);
			wait_for(0, 100);
			@(negedge clk);
			check(olen, s ? LC + 1 : SC + 1);
			wr(ADDR_EXT_CONFIG, 8'h00);
		end
		rd(ADDR_EVENT_FLAGS, 8'h10);
		src <= 2'b00;
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_EXT_CONFIG, 8'h10);
			wait_for(1, 300);
			wr(k == 0 ? ADDR_EVENT_FLAGS : k == 1 ? ADDR_IRQ_CONTROL : ADDR_EXT_CONFIG, 8'h00);
			@(negedge clk);
			check(irq_pin, 1'b1);
			wr(ADDR_IRQ_CONTROL, 8'h10);
			wr(ADDR_EXT_CONFIG, 8'h00);
		end
		@(negedge clk);
		check(timer_running, 1'b0);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h00);
		wr(ADDR_EXT_CONFIG, 8'h10);
		wait_for(1, 300);
		check(irq_n_oe, 1'b0);
		rd(ADDR_EVENT_FLAGS, 8'h10);
		halt <= 1'b1;
		wr(ADDR_EXT_CONFIG, 8'h11);
		repeat (200) begin
			@(negedge clk);
			if (timer_event !== 1'b0)
				nev++;
		end
		check(nev, 0);
		wr(ADDR_EXT_CONFIG, 8'h10);
		wait_for(1, 300);
		halt <= 1'b0;
		wr(ADDR_EXT_CONFIG, 8'h00);
		// Write with ce low must be ignored
		ce <= 1'b0;
		wr(ADDR_PRESET_LOW, 8'h55);
		ce <= 1'b1;
		rd(ADDR_PRESET_LOW, 8'h08);
		for (int k = 1; k < 4; k++) begin
			@(posedge clk);
			{alm, upd} <= 2'(k);
			@(negedge clk);
			check(irq_pin, 1'b0);
		end
		@(posedge clk);
		{alm, upd} <= 2'b00;
		@(negedge clk);
		check(irq_pin, 1'b1);
		complete_run();
	end
endmodule : tb_top
